// File: src/ocw_pkg.sv
// Shared constants and types for the oscillator divider, wake-up and clock output select block.
package ocw_pkg;
   // Register indices; the APB byte address is four times the index.
   localparam logic [15:0] IDX_AUX_SEL  = 16'h1C82;
   localparam logic [15:0] IDX_DIV_CTL  = 16'h1C92;
   localparam logic [15:0] IDX_WAKE_EN  = 16'h1C98;
   localparam logic [15:0] IDX_PLL_CS   = 16'h1CA0;
   localparam logic [15:0] IDX_PIN_SEL  = 16'h8400;
   localparam int          ADDR_W       = 18;
   // Field positions.
   localparam int          DIV_EN_BIT   = 15;
   localparam int          DIV_RAT_LSB  = 0;
   localparam int          PIN_DIS_BIT  = 0;
   localparam int          PIN_SRC_LSB  = 1;
   localparam int          PD_BIT       = 0;
   localparam int          STAB_BIT     = 1;
   // Reset values.
   localparam logic [4:0]  DIV_RAT_RST  = 5'h00;
   localparam logic        DIV_EN_RST   = 1'b0;
   localparam logic [4:0]  WAKE_EN_RST  = 5'h1F;
   localparam logic [3:0]  AUX_SEL_RST  = 4'hB;
   localparam logic [1:0]  PIN_SRC_RST  = 2'h1;
   localparam logic        PIN_DIS_RST  = 1'b0;
   // Auxiliary output select codes above the divider range.
   localparam logic [3:0]  AUX_TAP_A    = 4'h9;
   localparam logic [3:0]  AUX_TAP_B    = 4'hA;
   localparam logic [3:0]  AUX_TAP_C    = 4'hB;
   // Oscillator stabilization count in reference clock cycles.
   localparam int          STAB_CYC_DEF = 41032;
   localparam int          STAB_W       = 16;

   // Oscillator divider control fields.
   typedef struct packed {
      logic       en;
      logic [4:0] ratio;
   } ocw_div_s;

   // Main clock pin selection fields.
   typedef struct packed {
      logic [1:0] src;
      logic       dis;
   } ocw_pin_s;

   // Oscillator state, Gray coded along run, down, stabilize.
   typedef enum logic [1:0] {
      OSC_RUN  = 2'b00,
      OSC_DOWN = 2'b01,
      OSC_STAB = 2'b11
   } ocw_osc_e;
endpackage

// File: src/ocw_top.sv
// Oscillator divider, oscillator wake-up control and clock output selection with an APB slave.
// Function
// - Auxiliary divider divides oscillator by ratio plus one, 1 to 32.
// - Divider stops while its enable bit is 0, runs while 1.
// - Ratio field in bits 4:0, read/write, resets to zero.
// - Reserved bits read zero; writes to them do nothing.
// - In power-down, rising edge on an enabled source wakes oscillator, clears flag.
// - A source whose wake bit is 1 never wakes the oscillator.
// - Wake bits 4..1 map to irq 3..0, bit 0 to nmi.
// - All five wake bits read/write, reset to 1.
// - Select 0-7 divider, 9/10/11 taps A/B/C, others unsupported.
// - Auxiliary select resets to 1011; other codes are debug only.
// - Pin source bits 2:1: 01/10/11 pick clocks one/two/three; 00 reserved; reset 01.
// - Pin disable bit 0 set holds main clock pin low; resets 0.
// - Wake from power-down counts 41,032 reference cycles before resuming.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ocw_top #(
   parameter int STAB_CYCLES = ocw_pkg::STAB_CYC_DEF
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [ocw_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       ext_irq_3,
   input  wire logic                       ext_irq_2,
   input  wire logic                       ext_irq_1,
   input  wire logic                       ext_irq_0,
   input  wire logic                       nmi_in,
   input  wire logic                       tap_a,
   input  wire logic                       tap_b,
   input  wire logic                       tap_c,
   input  wire logic                       system_clock_one,
   input  wire logic                       system_clock_two,
   input  wire logic                       system_clock_three,
   output logic                            aux_clock_out,
   output logic                            main_clock_pin,
   output logic                            osc_running,
   output logic                            program_resume
);
   import ocw_pkg::*;

   localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES - 1);

   // Register state.
   ocw_div_s          div_r;
   logic [4:0]        wake_en_r;
   logic [3:0]        aux_sel_r;
   ocw_pin_s          pin_r;
   ocw_osc_e          osc_r;
   ocw_osc_e          osc_nxt;
   logic [STAB_W-1:0] stab_cnt_r;
   logic              prun_r;
   logic              run_r;

   // Two-flop synchronisers for every asynchronous input.
   logic [10:0]       async_in;
   logic [10:0]       meta_r;
   logic [10:0]       sync_r;
   logic [4:0]        wake_prev_r;

   // Divider and output path state.
   logic [4:0]        cnt_r;
   logic [4:0]        act_ratio_r;
   logic              act_en_r;
   logic [3:0]        act_aux_r;
   ocw_pin_s          act_pin_r;
   logic              div_out_r;
   logic              aux_r;
   logic              pin_r_out;

   // APB registered answer.
   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;

   assign async_in = {system_clock_three, system_clock_two, system_clock_one,
                      tap_c, tap_b, tap_a,
                      ext_irq_3, ext_irq_2, ext_irq_1, ext_irq_0, nmi_in};

   // Only the second stage is read by logic; the first stage only feeds it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 11'h000;
         sync_r <= 11'h000;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   // APB decode; a register index is the byte address divided by four.
   wire [ADDR_W-1:0] a_aux  = ADDR_W'({IDX_AUX_SEL, 2'b00});
   wire [ADDR_W-1:0] a_div  = ADDR_W'({IDX_DIV_CTL, 2'b00});
   wire [ADDR_W-1:0] a_wake = ADDR_W'({IDX_WAKE_EN, 2'b00});
   wire [ADDR_W-1:0] a_pll  = ADDR_W'({IDX_PLL_CS, 2'b00});
   wire [ADDR_W-1:0] a_pin  = ADDR_W'({IDX_PIN_SEL, 2'b00});
   wire hit_aux  = (paddr == a_aux);
   wire hit_div  = (paddr == a_div);
   wire hit_wake = (paddr == a_wake);
   wire hit_pll  = (paddr == a_pll);
   wire hit_pin  = (paddr == a_pin);
   wire hit_any  = hit_aux | hit_div | hit_wake | hit_pll | hit_pin;
   wire setup_ph = psel & ~penable;
   wire wr_go    = psel & penable & pready_r & pwrite & hit_any;

   // Read mux; reserved bits are built as zero.
   wire [31:0] rd_div  = {16'h0000, div_r.en, 10'h000, div_r.ratio};
   wire [31:0] rd_wake = {27'h0000000, wake_en_r};
   wire [31:0] rd_aux  = {28'h0000000, aux_sel_r};
   wire [31:0] rd_pin  = {29'h00000000, pin_r.src, pin_r.dis};
   wire [31:0] rd_pll  = {30'h00000000, osc_r == OSC_STAB, osc_r == OSC_DOWN};
   wire [31:0] rd_mux  = hit_div  ? rd_div  :
                         hit_wake ? rd_wake :
                         hit_aux  ? rd_aux  :
                         hit_pin  ? rd_pin  :
                         hit_pll  ? rd_pll  : 32'h00000000;

   // The answer is prepared in the setup phase so that pready rises in the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setup_ph;
         prdata_r  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
         pslverr_r <= setup_ph & ~hit_any;
      end
   end

   // Software-visible control registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // ratio resets to divide by one
         div_r.ratio <= DIV_RAT_RST;
         div_r.en    <= DIV_EN_RST;
         wake_en_r   <= WAKE_EN_RST;
         aux_sel_r   <= AUX_SEL_RST;
         pin_r.src   <= PIN_SRC_RST;
         pin_r.dis   <= PIN_DIS_RST;
      end else if (wr_go) begin
         if (hit_div) begin
            div_r.ratio <= pwdata[DIV_RAT_LSB +: 5];
            div_r.en    <= pwdata[DIV_EN_BIT];
         end
         if (hit_wake) begin
            wake_en_r <= pwdata[4:0];
         end
         if (hit_aux) begin
            aux_sel_r <= pwdata[3:0];
         end
         if (hit_pin) begin
            pin_r.src <= pwdata[PIN_SRC_LSB +: 2];
            pin_r.dis <= pwdata[PIN_DIS_BIT];
         end
      end
   end

   // Wake edge detection on the synchronised interrupt inputs.
   wire [4:0] wake_now  = sync_r[4:0];
   wire [4:0] wake_rise = wake_now & ~wake_prev_r;
   // only sources with a zero enable bit count
   wire       wake_hit  = |(wake_rise & ~wake_en_r);
   wire       pd_write  = wr_go & hit_pll & pwdata[PD_BIT];

   // Previous level resets low, the idle level of the pins, so no false edge follows reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_prev_r <= 5'h00;
      end else begin
         wake_prev_r <= wake_now;
      end
   end

   // Oscillator state: software powers down, an enabled wake edge restarts it.
   always_comb begin
      osc_nxt = osc_r;
      case (osc_r)
         OSC_RUN: begin
            if (pd_write) begin
               osc_nxt = OSC_DOWN;
            end
         end
         OSC_DOWN: begin
            if (wake_hit) begin
               osc_nxt = OSC_STAB;
            end
         end
         OSC_STAB: begin
            if (stab_cnt_r == STAB_LAST) begin
               osc_nxt = OSC_RUN;
            end
         end
         default: begin
            osc_nxt = OSC_RUN;
         end
      endcase
   end

   // State register, stabilization counter and the registered running and resume outputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_r      <= OSC_RUN;
         stab_cnt_r <= '0;
         prun_r     <= 1'b0;
         run_r      <= 1'b1;
      end else begin
         osc_r      <= osc_nxt;
         stab_cnt_r <= (osc_r == OSC_STAB) ? stab_cnt_r + 1'b1 : '0;
         prun_r     <= (osc_r == OSC_STAB) && (osc_nxt == OSC_RUN);
         // Taken from the next state, so the running flag rises in the same cycle as the resume pulse.
         run_r      <= (osc_nxt == OSC_RUN);
      end
   end

   // Divider runs only with the oscillator up and its enable set.
   wire osc_up   = (osc_r == OSC_RUN);
   wire cnt_last = (cnt_r == act_ratio_r);
   // High for the first half of the period, rounded up, so divide by one stays high.
   wire [5:0] half   = (6'(act_ratio_r) + 6'd2) >> 1;
   wire       div_hi = act_en_r & osc_up & (6'(cnt_r) < half);

   // Period counter; the active ratio and enable are copies of the software fields.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r       <= 5'h00;
         act_ratio_r <= DIV_RAT_RST;
         act_en_r    <= DIV_EN_RST;
         div_out_r   <= 1'b0;
      end else begin
         // new ratio and enable at a period boundary or while disabled or the oscillator is down
         if (cnt_last | ~act_en_r | ~osc_up) begin
            act_ratio_r <= div_r.ratio;
            act_en_r    <= div_r.en;
            cnt_r       <= 5'h00;
         end else begin
            cnt_r <= cnt_r + 5'h01;
         end
         // period is ratio plus one cycles
         div_out_r <= div_hi;
      end
   end

   // Source selection for the two clock outputs.
   wire aux_next = (act_aux_r[3] == 1'b0) ? div_out_r :
                   (act_aux_r == AUX_TAP_A) ? sync_r[5] :
                   (act_aux_r == AUX_TAP_B) ? sync_r[6] :
                   (act_aux_r == AUX_TAP_C) ? sync_r[7] : 1'b0;
   // While the pin is low the new selection applies at once, so the old one cannot raise a disabled pin.
   ocw_pin_s pin_use;
   assign pin_use = pin_r_out ? act_pin_r : pin_r;
   wire pin_sel  = (pin_use.src == 2'h1) ? sync_r[8] :
                   (pin_use.src == 2'h2) ? sync_r[9] :
                   (pin_use.src == 2'h3) ? sync_r[10] : 1'b0;
   wire pin_next = ~pin_use.dis & pin_sel;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_aux_r <= AUX_SEL_RST;
         act_pin_r <= '{src: PIN_SRC_RST, dis: PIN_DIS_RST};
         aux_r     <= 1'b0;
         pin_r_out <= 1'b0;
      end else begin
         // switch while the output is low
         if (!aux_r) begin
            act_aux_r <= aux_sel_r;
         end
         if (!pin_r_out) begin
            act_pin_r <= pin_r;
         end
         aux_r     <= aux_next;
         pin_r_out <= pin_next;
      end
   end

   // Every output is taken straight from its register.
   assign prdata         = prdata_r;
   assign pready         = pready_r;
   assign pslverr        = pslverr_r;
   assign aux_clock_out  = aux_r;
   assign main_clock_pin = pin_r_out;
   assign osc_running    = run_r;
   assign program_resume = prun_r;
endmodule
`default_nettype wire

// File: tb/ocw_top_bench.sv
// Self-checking bench for ocw_top driven over APB.
`timescale 1ns/1ps
`default_nettype none
bind ocw_top ocw_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .main_clock_pin(main_clock_pin), .osc_running(osc_running), .program_resume(program_resume));
module ocw_top_bench;
   import ocw_pkg::*;
   localparam int     STAB = 20;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, aux, pin, run, res, erv;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rdv;
   logic [4:0]        ws;
   logic [2:0]        tp, sc;
   int                mismatches, cmp_count, t;
   logic [15:0]       ridx [4] = '{IDX_AUX_SEL, IDX_DIV_CTL, IDX_WAKE_EN, IDX_PIN_SEL};
   logic [31:0]       rmsk [4] = '{32'hF, 32'h801F, 32'h1F, 32'h7};
   int                rt [4] = '{1, 2, 5, 31};
   ocw_top #(.STAB_CYCLES(STAB)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_irq_3(ws[4]), .ext_irq_2(ws[3]), .ext_irq_1(ws[2]), .ext_irq_0(ws[1]), .nmi_in(ws[0]),
      .tap_a(tp[0]), .tap_b(tp[1]), .tap_c(tp[2]), .system_clock_one(sc[0]), .system_clock_two(sc[1]),
      .system_clock_three(sc[2]), .aux_clock_out(aux), .main_clock_pin(pin), .osc_running(run),
      .program_resume(res));
   // Free-running 125 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Compare one value and count it.
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; the request holds until ready is sampled high.
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ADDR_W'({idx, 2'h0});
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(nm, rdv, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Cycles between two rising edges of the auxiliary output.
   task automatic per(output int p);
      int   n;
      int   t0;
      logic pv;
      p = 0;
      t0 = -1;
      pv = aux;
      for (n = 0; n < 200 && p == 0; n++) begin
         @(posedge pclk);
         if (aux === 1'b1 && pv === 1'b0) begin
            if (t0 < 0) t0 = n;
            else p = n - t0;
         end
         pv = aux;
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      {psel, penable, pwrite, presetn, ws, tp, sc} = '0;
      paddr = '0;
      pwdata = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc("aux reset", IDX_AUX_SEL, 32'hB);
      rdc("div reset", IDX_DIV_CTL, 32'h0);
      rdc("wake reset", IDX_WAKE_EN, 32'h1F);
      rdc("pin reset", IDX_PIN_SEL, 32'h2);
      // All-ones writes must read back only the fields.
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ridx[i], 32'hFFFFFFFF);
         rdc("field mask", ridx[i], rmsk[i]);
      end
      apb(1'b1, 16'h0001, 32'hFFFF);
      chk("unmapped err", 32'(erv), 32'h1);
      apb(1'b0, 16'h0001, 32'h0);
      chk("unmapped data", rdv, 32'h0);
      // Divider periods under several divider-select codes.
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, IDX_DIV_CTL, 32'h8000 | 32'(rt[i]));
         apb(1'b1, IDX_AUX_SEL, 32'(i * 2));
         cyc(80);
         per(t);
         chk("div period", 32'(t), 32'(rt[i] + 1));
      end
      apb(1'b1, IDX_DIV_CTL, 32'h8000);
      cyc(40);
      chk("div by one", 32'(aux), 32'h1);
      apb(1'b1, IDX_DIV_CTL, 32'h0);
      cyc(40);
      chk("div off", 32'(aux), 32'h0);
      // Taps one-hot, so a wrong route reads low; code 12 is unsupported.
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, IDX_AUX_SEL, 32'(9 + i));
         tp <= (i == 3) ? 3'h7 : 3'(1 << i);
         cyc(8);
         chk("aux tap", 32'(aux), (i == 3) ? 32'h0 : 32'h1);
         tp <= 3'h0;
         cyc(8);
      end
      // Source changes apply only while the pin is low, so sources idle first.
      for (int i = 0; i < 4; i++) begin
         sc <= 3'h0;
         cyc(8);
         apb(1'b1, IDX_PIN_SEL, 32'((i << 1) | 1));
         sc <= (i == 0) ? 3'h7 : 3'(1 << (i - 1));
         cyc(8);
         chk("pin disabled", 32'(pin), 32'h0);
         apb(1'b1, IDX_PIN_SEL, 32'(i << 1));
         cyc(8);
         chk("pin source", 32'(pin), (i == 0) ? 32'h0 : 32'h1);
      end
      // Each source wakes only through its own bit; the others rise first.
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, IDX_WAKE_EN, 32'(5'h1F ^ (5'h1 << i)));
         apb(1'b1, IDX_PLL_CS, 32'h1);
         ws <= 5'h1F ^ (5'h1 << i);
         cyc(10);
         chk("masked wake", 32'(run), 32'h0);
         rdc("flag set", IDX_PLL_CS, 32'h1);
         ws <= 5'h1F;
         t = 0;
         while (res !== 1'b1 && t < 200) begin
            @(posedge pclk);
            t++;
         end
         chk("wake delay", 32'(t >= STAB && t <= STAB + 5), 32'h1);
         rdc("flag cleared", IDX_PLL_CS, 32'h0);
         ws <= 5'h0;
         cyc(4);
      end
      give_verdict();
   end
   // Watchdog well beyond the roughly one thousand cycles the tests need.
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire

// File: tb/ocw_top_monitor.sv
// Checker for the bus, wake and pin outputs of ocw_top.
`timescale 1ns/1ps
`default_nettype none
module ocw_top_monitor (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [ocw_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       main_clock_pin,
   input wire logic                       osc_running,
   input wire logic                       program_resume
);
   import ocw_pkg::*;
   logic pin_dis_r;
   wire  pin_wr = psel && penable && pready && pwrite && paddr == ADDR_W'({IDX_PIN_SEL, 2'h0});
   // Shadow of the pin disable bit; only completed writes count.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) pin_dis_r <= 1'b0;
      else if (pin_wr) pin_dis_r <= pwdata[0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no answer in the first access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("error flag outside an answer");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside an answer");
   a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   a_resume_pulse: assert property (program_resume |=> !program_resume)
      else $error("resume pulse too long");
   a_resume_wakes: assert property ($rose(osc_running) |-> program_resume)
      else $error("oscillator running without resume");
   a_pin_stays_low: assert property (pin_dis_r && !main_clock_pin |=> !main_clock_pin)
      else $error("disabled pin went high");
   c_resume: cover property (program_resume);
   c_refused: cover property (pslverr);
   c_pin_off: cover property (pin_dis_r && !main_clock_pin);
endmodule
`default_nettype wire
